// >>> aid_map.svh
`ifndef AID_MAP_SVH
`define AID_MAP_SVH
// Behaviour
// RULE_01 - Flags bits 0-3: failure, internal, external, channel
// RULE_02 - Bit 4 aux supply missing, bit 7 parametrization
// RULE_03 - Module class bits 3:0 read 0101b
// RULE_04 - Info bit 4 marks channel information present
// RULE_05 - Extra flags bit 4 internal communication error
// RULE_06 - Channel kind code 71h, bit 7 reserved
// RULE_07 - Eight diagnostic bits per channel
// RULE_08 - Channel count reads eight
// RULE_09 - Summary bit n set on channel n error
// RULE_10 - Channel byte bit 0 parameter error
// RULE_11 - Channel byte bit 6 underflow, 7 overflow
// RULE_12 - Timestamp holds ticker at diagnostic event
// RULE_13 - Ticker starts at zero, counts microseconds
// RULE_14 - Ticker wraps after 2^32-1 as unsigned
// RULE_15 - Error drives channel indicator, no interrupt
// RULE_16 - Any channel flag sets summary and module bit
// RULE_17 - Timestamp loads all 32 bits at once

// Record byte indices
`define AID_IDX_MOD_FLAGS 5'h00
`define AID_IDX_MOD_INFO 5'h01
`define AID_IDX_RSVD_C 5'h02
`define AID_IDX_EXTRA_FLAGS 5'h03
`define AID_IDX_CH_KIND 5'h04
`define AID_IDX_DIAG_BITS 5'h05
`define AID_IDX_CH_COUNT 5'h06
`define AID_IDX_CH_SUMMARY 5'h07
`define AID_IDX_CH_ERR0 5'h08
`define AID_IDX_TSTAMP0 5'h10
`define AID_IDX_LAST 5'h13

// Field positions
`define AID_MF_FAIL 0
`define AID_MF_INT 1
`define AID_MF_EXT 2
`define AID_MF_CHAN 3
`define AID_MF_AUX 4
`define AID_MF_PARM 7
`define AID_XF_COMM 4
`define AID_MI_CHINFO 4
`define AID_CE_PARM 0
`define AID_CE_UNDER 6
`define AID_CE_OVER 7

// Constant values
`define AID_MOD_CLASS_ANALOG 4'h5
`define AID_CH_KIND_AI 7'h71
`define AID_DIAG_BITS 8'h08
`define AID_CH_COUNT 8'h08
`define AID_RESET_BYTE 8'h00

// Ticker timing
`define AID_CLK_PERIOD_PS 5000
`define AID_TICK_PERIOD_PS 1000000
`define AID_TICK_CYCLES (`AID_TICK_PERIOD_PS / `AID_CLK_PERIOD_PS)
`endif

// >>> aid_pkg.sv
package aid_pkg;
  typedef logic [7:0] aid_byte_t;
  typedef logic [4:0] aid_idx_t;
  typedef logic [31:0] aid_tick_t;
endpackage

// >>> aid_ticker.sv
`timescale 1ns/1ps
`include "aid_map.svh"
module aid_ticker #(
  parameter int CYCLES = `AID_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  output aid_pkg::aid_tick_t o_count
);
  import aid_pkg::*;
  localparam int PW = $clog2(CYCLES);
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  aid_tick_t cnt_r;
  wire tick = (pre_r == PW'(CYCLES - 1));

  // Elaboration check; a one-cycle prescaler would never leave zero
  if (CYCLES < 2) begin : g_bad_cycles
    $error("aid_ticker: CYCLES must be at least 2");
  end

  assign pre_nxt = tick ? '0 : pre_r + 1'b1;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_r <= '0;
      cnt_r <= '0; // RULE_13
    end else begin
      pre_r <= pre_nxt;
      if (tick) begin
        cnt_r <= cnt_r + 32'h0000_0001; // RULE_14
      end
    end
  end

  assign o_count = cnt_r;

  a_tick_step: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $past(tick) |-> o_count == $past(o_count) + 32'h0000_0001) // RULE_14
    else $error("ticker did not step");
  a_tick_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !$past(tick) |-> $stable(o_count)) // RULE_13
    else $error("ticker moved between ticks");
endmodule

// >>> aid_ch_err.sv
`timescale 1ns/1ps
`include "aid_map.svh"
module aid_ch_err (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_parm_err,
  input wire logic i_underflow,
  input wire logic i_overflow,
  output aid_pkg::aid_byte_t o_err_byte,
  output logic o_any
);
  import aid_pkg::*;
  aid_byte_t err_r;
  aid_byte_t err_nxt;

  always_comb begin
    err_nxt = `AID_RESET_BYTE;
    err_nxt[`AID_CE_PARM] = i_parm_err; // RULE_10
    err_nxt[`AID_CE_UNDER] = i_underflow; // RULE_11
    err_nxt[`AID_CE_OVER] = i_overflow; // RULE_11
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err_r <= `AID_RESET_BYTE;
    end else begin
      err_r <= err_nxt;
    end
  end

  assign o_err_byte = err_r;
  assign o_any = |err_r; // RULE_16

  a_ch_rsvd: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_err_byte[5:1] == 5'h00) // RULE_10
    else $error("reserved channel bits set");
  a_ch_over: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_overflow |=> o_err_byte[`AID_CE_OVER] && o_any) // RULE_11
    else $error("overflow not recorded");
endmodule

// >>> aid_diag_record.sv
`timescale 1ns/1ps
`include "aid_map.svh"
// Read-only diagnostic record; sources are sampled levels, cleared by the source.
module aid_diag_record #(
  parameter int NUM_CH = 8,
  parameter int TICK_CYCLES = `AID_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_mod_fail,
  input wire logic i_int_err,
  input wire logic i_ext_err,
  input wire logic i_aux_missing,
  input wire logic i_parm_err,
  input wire logic i_comm_err,
  input wire logic [NUM_CH-1:0] i_ch_parm_err,
  input wire logic [NUM_CH-1:0] i_ch_underflow,
  input wire logic [NUM_CH-1:0] i_ch_overflow,
  input wire logic i_rd_en,
  input aid_pkg::aid_idx_t i_rd_idx,
  output aid_pkg::aid_byte_t o_rd_data,
  output logic o_rd_valid,
  output logic [NUM_CH-1:0] o_ch_led,
  output aid_pkg::aid_tick_t o_ticker
);
  import aid_pkg::*;

  if (NUM_CH != 8) begin : g_bad_num_ch
    $error("aid_diag_record: record layout serves eight channels");
  end

  aid_byte_t ch_err [NUM_CH];
  logic [NUM_CH-1:0] ch_any;
  aid_tick_t ticker;
  aid_byte_t mod_flags_r;
  aid_byte_t mod_flags_nxt;
  aid_byte_t extra_flags_r;
  aid_byte_t extra_flags_nxt;
  aid_byte_t summary_r;
  aid_tick_t stamp_r;
  aid_byte_t rd_data_r;
  logic rd_valid_r;
  logic diag_any;
  logic diag_any_d_r;
  logic event_rise;

  aid_ticker #(.CYCLES(TICK_CYCLES)) u_ticker (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .o_count(ticker)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      aid_ch_err u_ch (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_parm_err(i_ch_parm_err[g]),
        .i_underflow(i_ch_underflow[g]),
        .i_overflow(i_ch_overflow[g]),
        .o_err_byte(ch_err[g]),
        .o_any(ch_any[g])
      );
    end
  endgenerate

  always_comb begin
    mod_flags_nxt = `AID_RESET_BYTE;
    mod_flags_nxt[`AID_MF_FAIL] = i_mod_fail; // RULE_01
    mod_flags_nxt[`AID_MF_INT] = i_int_err; // RULE_01
    mod_flags_nxt[`AID_MF_EXT] = i_ext_err; // RULE_01
    mod_flags_nxt[`AID_MF_CHAN] = |ch_any; // RULE_16
    mod_flags_nxt[`AID_MF_AUX] = i_aux_missing; // RULE_02
    mod_flags_nxt[`AID_MF_PARM] = i_parm_err; // RULE_02
    extra_flags_nxt = `AID_RESET_BYTE;
    extra_flags_nxt[`AID_XF_COMM] = i_comm_err; // RULE_05
  end

  // Event = first flag coming up while no other flag stands; a rising edge only, so a standing error keeps its stamp
  assign diag_any = |mod_flags_nxt | |extra_flags_nxt;
  assign event_rise = diag_any && !diag_any_d_r;

  wire aid_byte_t info_byte = {3'b000, 1'b1, `AID_MOD_CLASS_ANALOG}; // RULE_03 RULE_04
  wire aid_byte_t kind_byte = {1'b0, `AID_CH_KIND_AI}; // RULE_06
  wire aid_idx_t ch_sel = aid_idx_t'(i_rd_idx - `AID_IDX_CH_ERR0);
  wire logic [1:0] ts_sel = i_rd_idx[1:0];

  function automatic aid_byte_t stamp_byte(input aid_tick_t t, input logic [1:0] s);
    stamp_byte = t[8*s +: 8];
  endfunction

  aid_byte_t rd_mux;
  always_comb begin
    if (i_rd_idx == `AID_IDX_MOD_FLAGS) begin
      rd_mux = mod_flags_r;
    end else if (i_rd_idx == `AID_IDX_MOD_INFO) begin
      rd_mux = info_byte;
    end else if (i_rd_idx == `AID_IDX_EXTRA_FLAGS) begin
      rd_mux = extra_flags_r;
    end else if (i_rd_idx == `AID_IDX_CH_KIND) begin
      rd_mux = kind_byte;
    end else if (i_rd_idx == `AID_IDX_DIAG_BITS) begin
      rd_mux = `AID_DIAG_BITS; // RULE_07
    end else if (i_rd_idx == `AID_IDX_CH_COUNT) begin
      rd_mux = `AID_CH_COUNT; // RULE_08
    end else if (i_rd_idx == `AID_IDX_CH_SUMMARY) begin
      rd_mux = summary_r;
    end else if (i_rd_idx >= `AID_IDX_CH_ERR0 && i_rd_idx < `AID_IDX_TSTAMP0) begin
      rd_mux = ch_err[ch_sel[2:0]];
    end else if (i_rd_idx >= `AID_IDX_TSTAMP0 && i_rd_idx <= `AID_IDX_LAST) begin
      rd_mux = stamp_byte(stamp_r, ts_sel);
    end else begin
      rd_mux = `AID_RESET_BYTE;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mod_flags_r <= `AID_RESET_BYTE;
      extra_flags_r <= `AID_RESET_BYTE;
      summary_r <= `AID_RESET_BYTE;
      stamp_r <= '0;
      diag_any_d_r <= 1'b0;
      rd_data_r <= `AID_RESET_BYTE;
      rd_valid_r <= 1'b0;
    end else begin
      mod_flags_r <= mod_flags_nxt;
      extra_flags_r <= extra_flags_nxt;
      summary_r <= ch_any; // RULE_09 RULE_16
      diag_any_d_r <= diag_any;
      if (event_rise) begin
        stamp_r <= ticker; // RULE_12 RULE_17
      end
      rd_valid_r <= i_rd_en;
      if (i_rd_en) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // Indicator follows the channel byte; no interrupt output exists by design
  assign o_ch_led = ch_any; // RULE_15
  assign o_rd_data = rd_data_r;
  assign o_rd_valid = rd_valid_r;
  assign o_ticker = ticker;

  a_flag_fail: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_mod_fail |=> mod_flags_r[`AID_MF_FAIL]) // RULE_01
    else $error("module failure flag missing");
  a_flag_rsvd: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    mod_flags_r[6:5] == 2'b00 && extra_flags_r[3:0] == 4'h0) // RULE_02
    else $error("reserved flag bits set");
  a_comm_flag: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_comm_err |=> extra_flags_r[`AID_XF_COMM]) // RULE_05
    else $error("comm error flag missing");
  a_info_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_rd_en && i_rd_idx == `AID_IDX_MOD_INFO |=> o_rd_valid && o_rd_data == 8'h15) // RULE_03
    else $error("module info wrong");
  a_kind_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_rd_en && i_rd_idx == `AID_IDX_CH_KIND |=> o_rd_data == 8'h71) // RULE_06
    else $error("channel kind wrong");
  a_count_read: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_rd_en && (i_rd_idx == `AID_IDX_CH_COUNT || i_rd_idx == `AID_IDX_DIAG_BITS)
    |=> o_rd_data == 8'h08) // RULE_08
    else $error("count byte wrong");
  a_summary_chan: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    1'b1 |=> summary_r == $past(ch_any)) // RULE_09
    else $error("summary mismatch");
  a_chan_flag: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (|ch_any) |=> mod_flags_r[`AID_MF_CHAN]) // RULE_16
    else $error("module channel flag missing");
  a_stamp_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    event_rise |=> stamp_r == $past(ticker)) // RULE_12
    else $error("timestamp not captured");
  a_stamp_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !event_rise |=> $stable(stamp_r)) // RULE_17
    else $error("timestamp changed without event");
endmodule

// >>> aid_reader.sv
`timescale 1ns/1ps
// Backplane reader model: one strobed read per call
module aid_reader (
  input wire logic i_clock,
  input aid_pkg::aid_byte_t i_rd_data,
  input wire logic i_rd_valid,
  output logic o_rd_en,
  output aid_pkg::aid_idx_t o_rd_idx
);
  import aid_pkg::*;
  initial begin
    o_rd_en = 1'b0;
    o_rd_idx = 5'h00;
  end
  // A missing answer returns unknown, so the caller's compare fails
  task automatic rd(input aid_idx_t idx, output aid_byte_t data);
    int k;
    data = 'x;
    @(posedge i_clock);
    o_rd_en <= 1'b1;
    o_rd_idx <= idx;
    @(posedge i_clock);
    o_rd_en <= 1'b0;
    for (k = 0; k < 4; k++) begin
      #1;
      if (i_rd_valid === 1'b1) begin
        data = i_rd_data;
        break;
      end
      @(posedge i_clock);
    end
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import aid_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [5:0] mf = 6'h00;
  logic [7:0] cp = 8'h00;
  logic [7:0] cu = 8'h00;
  logic [7:0] co = 8'h00;
  logic rd_en;
  logic rd_valid;
  logic [7:0] led;
  aid_idx_t rd_idx;
  aid_byte_t d;
  aid_tick_t tick;
  aid_tick_t t;
  aid_tick_t ts;
  int n_errors = 0;
  int tests_run = 0;
  int k;
  int pos[6] = '{0, 1, 2, 4, 7, 4};
  aid_byte_t cb[3] = '{8'h01, 8'h40, 8'h80};
  // Short tick period keeps the run small
  aid_diag_record #(.NUM_CH(8), .TICK_CYCLES(4)) aid_diag_record_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_mod_fail(mf[0]), .i_int_err(mf[1]),
    .i_ext_err(mf[2]), .i_aux_missing(mf[3]), .i_parm_err(mf[4]), .i_comm_err(mf[5]),
    .i_ch_parm_err(cp), .i_ch_underflow(cu), .i_ch_overflow(co), .i_rd_en(rd_en),
    .i_rd_idx(rd_idx), .o_rd_data(d), .o_rd_valid(rd_valid), .o_ch_led(led),
    .o_ticker(tick));
  aid_reader aid_reader_i (.i_clock(i_clock), .i_rd_data(d), .i_rd_valid(rd_valid),
    .o_rd_en(rd_en), .o_rd_idx(rd_idx));
  always #2.5 i_clock = ~i_clock;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic rchk(input aid_idx_t i, input aid_byte_t e);
    aid_byte_t g;
    aid_reader_i.rd(i, g);
    `CHK($sformatf("byte %h", i), e, g)
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    #1 `CHK("ticker", 32'h0000_0000, tick)
    rchk(5'h01, 8'h15);
    rchk(5'h04, 8'h71);
    rchk(5'h05, 8'h08);
    rchk(5'h06, 8'h08);
    rchk(5'h00, 8'h00);
    rchk(5'h02, 8'h00);
    rchk(5'h14, 8'h00);
    // Each module-level source alone, so a swapped bit shows
    for (int n = 0; n < 6; n++) begin
      @(posedge i_clock);
      mf <= 6'(1 << n);
      repeat (3) @(posedge i_clock);
      rchk((n == 5) ? 5'h03 : 5'h00, 8'(1 << pos[n]));
    end
    @(posedge i_clock);
    mf <= 6'h00;
    for (int n = 0; n < 8; n++) begin
      @(posedge i_clock);
      cp <= (n % 3 == 0 || n == 7) ? 8'(1 << n) : 8'h00;
      cu <= (n % 3 == 1 || n == 7) ? 8'(1 << n) : 8'h00;
      co <= (n % 3 == 2 || n == 7) ? 8'(1 << n) : 8'h00;
      repeat (3) @(posedge i_clock);
      rchk(5'(8 + n), (n == 7) ? 8'hC1 : cb[n % 3]);
      rchk(5'h07, 8'(1 << n));
      rchk(5'h00, 8'h08);
      `CHK("led", 8'(1 << n), led)
    end
    @(posedge i_clock);
    cp <= 8'h00;
    cu <= 8'h00;
    co <= 8'h00;
    repeat (4) @(posedge i_clock);
    // Raise the event just after a tick so the capture cannot straddle one
    #1 t = tick;
    k = 0;
    while (tick === t && k < 10) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    `CHK("tick seen", 1'b1, k < 10)
    t = tick;
    @(posedge i_clock);
    mf <= 6'h02;
    // Tick period is four cycles: no step before the fourth edge
    repeat (2) @(posedge i_clock);
    #1 `CHK("ticker hold", t, tick)
    @(posedge i_clock);
    #1 `CHK("ticker step", t + 32'h0000_0001, tick)
    for (int i = 0; i < 4; i++) begin
      aid_reader_i.rd(5'(16 + i), ts[8*i+:8]);
    end
    `CHK("timestamp", t, ts)
    stop_test();
  end
endmodule
